/* File: rtl/ptb_pkg.sv */
// shared constants and types for the probe trigger / break-in pin control
package ptb_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // register word addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h8;

  // control register fields
  localparam int unsigned CTRL_TRIG_LSB = 0;
  localparam int unsigned CTRL_BRK_LSB = 2;
  localparam int unsigned CTRL_LIVE_BIT = 4;

  // command register fields (write-only pulses)
  localparam int unsigned CMD_DISC_BIT = 0;
  localparam int unsigned CMD_REEN_BIT = 1;

  // status register fields
  localparam int unsigned STAT_COMP_BIT = 0;
  localparam int unsigned STAT_BG_BIT = 1;
  localparam int unsigned STAT_DIS_BIT = 2;
  localparam int unsigned STAT_LIVE_BIT = 3;
  localparam int unsigned STAT_BRK_BIT = 4;

  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    TRIG_FIX_HIGH,
    TRIG_FIX_LOW,
    TRIG_MON_HIGH,
    TRIG_MON_LOW
  } ptb_trig_sel_type;

  typedef enum logic [1:0] {
    BRK_OFF,
    BRK_RISING,
    BRK_FALLING
  } ptb_brk_sel_type;

  localparam ptb_trig_sel_type TRIG_DEFAULT = TRIG_MON_HIGH;
  localparam ptb_brk_sel_type BRK_DEFAULT = BRK_RISING;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ptb_bus_req_type;

  typedef struct packed {
    logic drive;
    logic oe;
  } ptb_pin_out_type;

endpackage

/* File: rtl/ptb_pin_ctrl.sv */
// probe-side trigger-out, break-in, target reset line and disconnect control
//
// How it works
// - trigger out: fixhigh, fixlow, monhigh (default), monlow
// - monlow drives low while target in background
// - companion attached pins trigger setting at default
// - companion attached pins break setting at rising
// - break input off never requests a break
// - break request on each selected edge
// - reset line low, or reference level if live-attach
// - disconnect command tri-states the target reset line driver; trigger out and break request keep driving
// - re-enable command restores the target reset line driver; disconnect wins if both are written together
`timescale 1ns/1ns
`default_nettype none

module ptb_pin_ctrl (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire ptb_pkg::ptb_bus_req_type bus_req_i,
  output logic [ptb_pkg::DATA_W-1:0] rdata_o,
  input wire logic companion_attached_i,
  input wire logic target_in_background_i,
  input wire logic break_in_i,
  output logic trig_out_o,
  output logic break_req_o,
  output ptb_pkg::ptb_pin_out_type target_system_reset_line_o
);
  import ptb_pkg::*;

  ptb_trig_sel_type trig_sel_r;
  ptb_brk_sel_type brk_sel_r;
  logic live_attach_r;
  logic rc_disabled_r;
  logic comp_meta_r, comp_s_r;
  logic bg_meta_r, bg_s_r;
  logic brk_meta_r, brk_s_r, brk_prev_r;
  logic brk_seen_r;
  logic brk_edge;
  logic disc_cmd, reen_cmd;

  function automatic logic is_write(input ptb_bus_req_type req, input logic [ADDR_W-1:0] a);
    is_write = req.wr && (req.addr == a);
  endfunction

  assign disc_cmd = is_write(bus_req_i, ADDR_CMD) && bus_req_i.wdata[CMD_DISC_BIT];
  assign reen_cmd = is_write(bus_req_i, ADDR_CMD) && bus_req_i.wdata[CMD_REEN_BIT];

  // pin synchronisers
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      comp_meta_r <= 1'b0;
      comp_s_r <= 1'b0;
      bg_meta_r <= 1'b0;
      bg_s_r <= 1'b0;
    end else begin
      comp_meta_r <= companion_attached_i;
      comp_s_r <= comp_meta_r;
      bg_meta_r <= target_in_background_i;
      bg_s_r <= bg_meta_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      brk_meta_r <= 1'b0;
      brk_s_r <= 1'b0;
      brk_prev_r <= 1'b0;
    end else begin
      brk_meta_r <= break_in_i;
      brk_s_r <= brk_meta_r;
      brk_prev_r <= brk_s_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      trig_sel_r <= TRIG_DEFAULT;
    end else if (comp_s_r) begin
      trig_sel_r <= TRIG_DEFAULT;
    end else if (is_write(bus_req_i, ADDR_CTRL)) begin
      trig_sel_r <= ptb_trig_sel_type'(bus_req_i.wdata[CTRL_TRIG_LSB +: 2]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      brk_sel_r <= BRK_DEFAULT;
    end else if (comp_s_r) begin
      brk_sel_r <= BRK_DEFAULT;
    end else if (is_write(bus_req_i, ADDR_CTRL) &&
                 bus_req_i.wdata[CTRL_BRK_LSB +: 2] != 2'h3) begin
      brk_sel_r <= ptb_brk_sel_type'(bus_req_i.wdata[CTRL_BRK_LSB +: 2]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      live_attach_r <= 1'b0;
    end else if (is_write(bus_req_i, ADDR_CTRL)) begin
      live_attach_r <= bus_req_i.wdata[CTRL_LIVE_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rc_disabled_r <= 1'b0;
    end else if (disc_cmd) begin
      rc_disabled_r <= 1'b1;
    end else if (reen_cmd) begin
      rc_disabled_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      trig_out_o <= 1'b0;
    end else begin
      unique case (trig_sel_r)
        TRIG_FIX_HIGH: trig_out_o <= 1'b1;
        TRIG_FIX_LOW: trig_out_o <= 1'b0;
        TRIG_MON_HIGH: trig_out_o <= bg_s_r;
        TRIG_MON_LOW: trig_out_o <= !bg_s_r;
      endcase
    end
  end

  always_comb begin
    brk_edge = 1'b0;
    unique case (brk_sel_r)
      BRK_OFF: brk_edge = 1'b0;
      BRK_RISING: brk_edge = brk_s_r && !brk_prev_r;
      BRK_FALLING: brk_edge = !brk_s_r && brk_prev_r;
      default: brk_edge = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      break_req_o <= 1'b0;
    end else begin
      break_req_o <= brk_edge;
    end
  end

  // sticky break seen, cleared by a status read; set wins
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      brk_seen_r <= 1'b0;
    end else if (brk_edge) begin
      brk_seen_r <= 1'b1;
    end else if (bus_req_i.rd && bus_req_i.addr == ADDR_STAT) begin
      brk_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      target_system_reset_line_o <= '{drive: 1'b0, oe: 1'b1};
    end else begin
      target_system_reset_line_o.drive <= live_attach_r;
      target_system_reset_line_o.oe <= !rc_disabled_r;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rdata_o <= DATA_ZERO;
    end else if (bus_req_i.rd) begin
      rdata_o <= DATA_ZERO;
      if (bus_req_i.addr == ADDR_CTRL) begin
        rdata_o[CTRL_TRIG_LSB +: 2] <= trig_sel_r;
        rdata_o[CTRL_BRK_LSB +: 2] <= brk_sel_r;
        rdata_o[CTRL_LIVE_BIT] <= live_attach_r;
      end else if (bus_req_i.addr == ADDR_STAT) begin
        rdata_o[STAT_COMP_BIT] <= comp_s_r;
        rdata_o[STAT_BG_BIT] <= bg_s_r;
        rdata_o[STAT_DIS_BIT] <= rc_disabled_r;
        rdata_o[STAT_LIVE_BIT] <= live_attach_r;
        rdata_o[STAT_BRK_BIT] <= brk_seen_r;
      end
    end else begin
      rdata_o <= DATA_ZERO;
    end
  end

  // checks
  property p_trig_fixhigh;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    trig_sel_r == TRIG_FIX_HIGH |=> trig_out_o;
  endproperty
  a_trig_fixhigh: assert property (p_trig_fixhigh) else $error("fixhigh not high");

  property p_trig_fixlow;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    trig_sel_r == TRIG_FIX_LOW |=> !trig_out_o;
  endproperty
  a_trig_fixlow: assert property (p_trig_fixlow) else $error("fixlow not low");

  property p_trig_monhigh;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    trig_sel_r == TRIG_MON_HIGH |=> trig_out_o == $past(bg_s_r);
  endproperty
  a_trig_monhigh: assert property (p_trig_monhigh) else $error("monhigh mismatch");

  property p_trig_monlow;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    trig_sel_r == TRIG_MON_LOW && bg_s_r |=> !trig_out_o;
  endproperty
  a_trig_monlow: assert property (p_trig_monlow) else $error("monlow high in background");

  property p_comp_pins;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    comp_s_r |=> trig_sel_r == TRIG_DEFAULT && brk_sel_r == BRK_DEFAULT;
  endproperty
  a_comp_pins: assert property (p_comp_pins) else $error("companion did not pin settings");

  property p_brk_off;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    brk_sel_r == BRK_OFF |=> !break_req_o;
  endproperty
  a_brk_off: assert property (p_brk_off) else $error("break while off");

  property p_brk_fall;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    brk_sel_r == BRK_FALLING && $fell(brk_s_r) |=> break_req_o;
  endproperty
  a_brk_fall: assert property (p_brk_fall) else $error("falling edge missed");

  property p_brk_single;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    break_req_o |=> !break_req_o;
  endproperty
  a_brk_single: assert property (p_brk_single) else $error("break pulse too long");

  property p_rst_live;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    live_attach_r |=> target_system_reset_line_o.drive;
  endproperty
  a_rst_live: assert property (p_rst_live) else $error("reset line low in live attach");

  property p_disc;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    disc_cmd |=> ##1 !target_system_reset_line_o.oe;
  endproperty
  a_disc: assert property (p_disc) else $error("disconnect not tri-stated");

  property p_reen;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    reen_cmd && !disc_cmd |=> ##1 target_system_reset_line_o.oe;
  endproperty
  a_reen: assert property (p_reen) else $error("re-enable not driving");

  property p_reset_dflt;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> trig_sel_r == TRIG_DEFAULT && brk_sel_r == BRK_DEFAULT
      && !live_attach_r && !rc_disabled_r;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("reset defaults wrong");

  property p_brk_rise;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    brk_sel_r == BRK_RISING && $rose(brk_s_r) |=> break_req_o;
  endproperty
  a_brk_rise: assert property (p_brk_rise) else $error("rising edge missed");

  property p_brk_cause;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    break_req_o |-> $past(brk_s_r) != $past(brk_s_r, 2);
  endproperty
  a_brk_cause: assert property (p_brk_cause) else $error("break without pin edge");

  property p_comp_no_fall;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    comp_s_r && $past(comp_s_r) && $fell(brk_s_r) |=> !break_req_o;
  endproperty
  a_comp_no_fall: assert property (p_comp_no_fall) else $error("falling break with companion");

  property p_rst_low;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !live_attach_r |=> !target_system_reset_line_o.drive;
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset line not held low");

  property p_disc_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rc_disabled_r && !reen_cmd |=> ##1 !target_system_reset_line_o.oe;
  endproperty
  a_disc_hold: assert property (p_disc_hold) else $error("driver back without re-enable");

endmodule // ptb_pin_ctrl

`default_nettype wire

/* File: bench/ptb_tgt_model.sv */
// target-side model: background state, break-in pin, reset line level
`timescale 1ns/1ns
`default_nettype none

module ptb_tgt_model (
  input wire ptb_pkg::ptb_pin_out_type rst_line_i,
  output logic rst_level_o,
  output logic target_in_background_o,
  output logic break_in_o
);
  import ptb_pkg::*;

  initial begin
    target_in_background_o = 1'h0;
    break_in_o = 1'h0;
  end

  // released line floats to its pull-up
  assign rst_level_o = rst_line_i.oe ? rst_line_i.drive : 1'h1;

  task automatic set_bg(input logic v);
    target_in_background_o <= v;
  endtask

  // pin frames at a 125 ns period, idle low between frames
  task automatic pulse(input int n);
    repeat (n) begin
      #63 break_in_o = 1'h1;
      #62 break_in_o = 1'h0;
    end
    #200;
  endtask
endmodule // ptb_tgt_model

`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the trigger / break-in pin control
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import ptb_pkg::*;
  logic ref_clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  ptb_bus_req_type req = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] d;
  logic comp = 1'h0;
  logic bg, brk_in, trig, brk_req, rst_level;
  ptb_pin_out_type rst_line;
  int failures = 0;
  int tests_run = 0;
  int brk_cnt = 0;

  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (brk_req === 1'h1) brk_cnt <= brk_cnt + 1;

  ptb_pin_ctrl dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .bus_req_i(req),
    .rdata_o(rdata), .companion_attached_i(comp), .target_in_background_i(bg),
    .break_in_i(brk_in), .trig_out_o(trig), .break_req_o(brk_req),
    .target_system_reset_line_o(rst_line));
  ptb_tgt_model tgt_u (.rst_line_i(rst_line), .rst_level_o(rst_level),
    .target_in_background_o(bg), .break_in_o(brk_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ref_clk_i);
    req <= '{addr: a, wdata: v, wr: 1'h1, rd: 1'h0};
    @(posedge ref_clk_i);
    req.wr <= 1'h0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk_i);
    req <= '{addr: a, wdata: DATA_ZERO, wr: 1'h0, rd: 1'h1};
    @(posedge ref_clk_i);
    req.rd <= 1'h0;
    #1 d = rdata;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic t_reset;
    rd(ADDR_CTRL);
    chk(d, 32'h6);
    chk(32'(rst_line), 32'h1);
    wait_clk(1);
    chk(rdata, 32'h0);
    rd(4'hC);
    chk(d, 32'h0);
  endtask

  task automatic t_trig;
    logic b;
    logic e;
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 2; i++) begin
        b = 1'(i);
        wr(ADDR_CTRL, 32'(c) | 32'h4);
        tgt_u.set_bg(b);
        wait_clk(6);
        e = (c == 0) ? 1'h1 : (c == 1) ? 1'h0 : (c == 2) ? b : ~b;
        chk(32'(trig), 32'(e));
      end
    end
    tgt_u.set_bg(1'h0);
  endtask

  task automatic t_brk;
    int s;
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_CTRL, (32'(c) << 2) | 32'h2);
      wait_clk(3);
      s = brk_cnt;
      tgt_u.pulse(3);
      chk(32'(brk_cnt - s), (c == 0) ? 32'h0 : 32'h3);
    end
  endtask

  task automatic t_comp;
    int s;
    comp <= 1'h1;
    wait_clk(4);
    wr(ADDR_CTRL, 32'h9);
    wait_clk(4);
    rd(ADDR_CTRL);
    chk(d, 32'h6);
    tgt_u.set_bg(1'h1);
    wait_clk(6);
    chk(32'(trig), 32'h1);
    s = brk_cnt;
    tgt_u.pulse(2);
    chk(32'(brk_cnt - s), 32'h2);
    tgt_u.set_bg(1'h0);
    comp <= 1'h0;
    wait_clk(4);
  endtask

  task automatic t_live;
    wr(ADDR_CTRL, 32'h16);
    wait_clk(3);
    chk(32'(rst_line), 32'h3);
    chk(32'(rst_level), 32'h1);
    wr(ADDR_CTRL, 32'h6);
    wait_clk(3);
    chk(32'(rst_line), 32'h1);
    chk(32'(rst_level), 32'h0);
  endtask

  task automatic t_disc;
    wr(ADDR_CMD, 32'h1);
    wait_clk(3);
    chk(32'(rst_line.oe), 32'h0);
    chk(32'(rst_level), 32'h1);
    rd(ADDR_STAT);
    chk(d, 32'h14);
    rd(ADDR_STAT);
    chk(d, 32'h4);
    wr(ADDR_CMD, 32'h2);
    wait_clk(3);
    chk(32'(rst_line), 32'h1);
    wr(ADDR_CMD, 32'h3);
    wait_clk(3);
    chk(32'(rst_line.oe), 32'h0);
    wr(ADDR_CMD, 32'h2);
    wait_clk(3);
    chk(32'(rst_line.oe), 32'h1);
  endtask

  // mid-run reset from a non-default setup
  task automatic t_rst2;
    wr(ADDR_CTRL, 32'h19);
    wr(ADDR_CMD, 32'h1);
    wait_clk(3);
    chk(32'(rst_line), 32'h2);
    @(posedge ref_clk_i);
    reset_n_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'h1;
    rd(ADDR_CTRL);
    chk(d, 32'h6);
    chk(32'(rst_line), 32'h1);
  endtask

  task automatic end_sim;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_i);
    reset_n_i <= 1'h1;
    t_reset;
    t_trig;
    t_brk;
    t_comp;
    t_live;
    t_disc;
    t_rst2;
    end_sim;
  end

  // hang guard well past the expected run
  initial begin
    #100000;
    failures++;
    end_sim;
  end
endmodule // tb_top

`default_nettype wire
